// ### rtl/reset_strap_latch.v
// Notes on behaviour
// RQ1: Device held in reset while reset pin low.
// RQ2: Straps captured at power-on and reset rising.
// RQ3: Capture at deassertion forms default configuration.
// RQ4: Port off only when both straps high.
// RQ5: Fixed-port strap sets non-removable port count.
// RQ6: Charge strap sets charging-enabled port count.
// RQ7: Operating mode chosen from three mode straps.
// RQ8: Board omits fixed-port resistor with SPI firmware.
// RQ9: Board holds straps steady before sampling.
// RQ10: Board supplies 25 MHz reference clock; the testbench drives core_clk at 200 MHz.
// RQ11: Fixed-port strap decodes to six settings.
// RQ12: Charge strap decodes to six settings.
// RQ13: Lower mode straps pick one of two pin sets.
// RQ14: Disabled USB 2.0 lane disables USB 3 lane.
// RQ15: Captured values hold between sampling events.
//
// Decided for this implementation: the AHB-Lite register port and the register addresses.
`timescale 1ns/10ps
`include "strap_defines.vh"

module reset_strap_latch #(
    parameter NUM_PORTS = 6
) (
    // Clock and power-on reset
    input wire core_clk,
    input wire rst_n,
    // External chip reset pin
    input wire ext_reset_n,
    // Strap inputs
    input wire [NUM_PORTS-1:0] port_dplus_off_strap,
    input wire [NUM_PORTS-1:0] port_dminus_off_strap,
    input wire [2:0] fixed_port_count_strap,
    input wire [2:0] charge_port_count_strap,
    input wire [2:0] mode_strap,
    // AHB-Lite slave
    input wire hsel,
    input wire [11:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [2:0] hsize,
    input wire [31:0] hwdata,
    input wire hready,
    output reg [31:0] hrdata,
    output reg hreadyout,
    output reg hresp,
    // Configuration outputs
    output reg dev_reset,
    output reg [NUM_PORTS-1:0] usb2_port_off,
    output reg [NUM_PORTS-1:0] usb3_port_off,
    output reg [NUM_PORTS-1:0] fixed_port_mask,
    output reg [NUM_PORTS-1:0] charge_port_mask,
    output reg [1:0] pin_config,
    output reg mode_reserved
);

    // One-hot reset sequencer
    localparam [1:0] ST_RESET = 2'b01;
    localparam [1:0] ST_RUN = 2'b10;

    // Six-level strap code to a mask of ports counted from port 1
    function [NUM_PORTS-1:0] count_mask;
        input [2:0] code;
        begin
            case (code)
                `LVL_200K_DN: count_mask = {NUM_PORTS{1'b0}};
                `LVL_200K_UP: count_mask = {{(NUM_PORTS-1){1'b0}}, 1'b1};
                `LVL_10K_DN: count_mask = {{(NUM_PORTS-2){1'b0}}, 2'b11};
                `LVL_10K_UP: count_mask = {{(NUM_PORTS-3){1'b0}}, 3'b111};
                `LVL_10R_DN: count_mask = {{(NUM_PORTS-4){1'b0}}, 4'b1111};
                `LVL_10R_UP: count_mask = {NUM_PORTS{1'b1}};
                default: count_mask = {NUM_PORTS{1'b0}};
            endcase
        end
    endfunction

    // Codes above the six resistor settings mean a misfitted strap
    function code_bad;
        input [2:0] code;
        begin
            code_bad = (code > `LVL_10R_UP);
        end
    endfunction

    // Captured strap state
    reg [1:0] state_ff;
    reg [1:0] nxt_state;
    reg [NUM_PORTS-1:0] dp_raw_ff;
    reg [NUM_PORTS-1:0] dm_raw_ff;
    reg [2:0] fix_raw_ff;
    reg [2:0] chg_raw_ff;
    reg [2:0] mode_raw_ff;
    reg [NUM_PORTS-1:0] strap_off_ff;
    reg fix_bad_ff;
    reg chg_bad_ff;
    reg [7:0] cap_cnt_ff;
    // Bus side
    reg [31:0] ctrl_ff;
    reg wr_pend_ff;
    reg [11:0] wr_addr_ff;
    wire capture;
    wire [NUM_PORTS-1:0] strap_off;
    wire [NUM_PORTS-1:0] sw_off;
    wire addr_phase;
    wire [31:0] raw_word;
    wire [31:0] cfg_word;
    wire [31:0] stat_word;
    reg [31:0] rd_word;

    // Reset sequencing
    // A stray state code falls back to reset, which recaptures the straps.
    // RQ1 reset follows pin
    always @* begin
        case (state_ff)
            ST_RESET: nxt_state = ext_reset_n ? ST_RUN : ST_RESET;
            ST_RUN: nxt_state = ext_reset_n ? ST_RUN : ST_RESET;
            default: nxt_state = ST_RESET;
        endcase
    end

    // RQ2 capture on release
    // The reset state is entered by power-on too, so one path serves both.
    assign capture = (state_ff == ST_RESET) && ext_reset_n;

    // A single high strap leaves the port enabled.
    // RQ4 both straps high
    genvar gi;
    generate
        for (gi = 0; gi < NUM_PORTS; gi = gi + 1) begin : g_port
            assign strap_off[gi] = port_dplus_off_strap[gi] & port_dminus_off_strap[gi];
        end
    endgenerate

    // Software override only adds ports; it never re-enables a strapped-off one.
    assign sw_off = ctrl_ff[`CTRL_OVR_BIT] ?
        ctrl_ff[`CTRL_MASK_LSB +: NUM_PORTS] : {NUM_PORTS{1'b0}};

    // dev_reset follows the next state so it drops on the capture edge itself.
    always @(posedge core_clk) begin
        if (!rst_n) begin
            state_ff <= ST_RESET;
            dev_reset <= 1'b1;
        end else begin
            state_ff <= nxt_state;
            // RQ1 reset output
            dev_reset <= (nxt_state == ST_RESET);
        end
    end

    // RQ3 latch at deassertion
    // RQ15 hold until next event
    // Raw levels are kept apart from the decoded views so software sees the pins as fitted.
    always @(posedge core_clk) begin
        if (!rst_n) begin
            dp_raw_ff <= {NUM_PORTS{1'b0}};
            dm_raw_ff <= {NUM_PORTS{1'b0}};
            fix_raw_ff <= 3'h0;
            chg_raw_ff <= 3'h0;
            mode_raw_ff <= 3'h0;
            strap_off_ff <= {NUM_PORTS{1'b0}};
        end else if (capture) begin
            dp_raw_ff <= port_dplus_off_strap;
            dm_raw_ff <= port_dminus_off_strap;
            fix_raw_ff <= fixed_port_count_strap;
            chg_raw_ff <= charge_port_count_strap;
            mode_raw_ff <= mode_strap;
            strap_off_ff <= strap_off;
        end
    end

    // RQ5 RQ11 fixed ports
    // Codes past the six settings leave every port removable.
    always @(posedge core_clk) begin
        if (!rst_n) begin
            fixed_port_mask <= {NUM_PORTS{1'b0}};
            fix_bad_ff <= 1'b0;
        end else if (capture) begin
            fixed_port_mask <= count_mask(fixed_port_count_strap);
            fix_bad_ff <= code_bad(fixed_port_count_strap);
        end
    end

    // RQ6 RQ12 charging ports
    // Charging stays off on a misfitted strap, the safe side.
    always @(posedge core_clk) begin
        if (!rst_n) begin
            charge_port_mask <= {NUM_PORTS{1'b0}};
            chg_bad_ff <= 1'b0;
        end else if (capture) begin
            charge_port_mask <= count_mask(charge_port_count_strap);
            chg_bad_ff <= code_bad(charge_port_count_strap);
        end
    end

    // RQ7 RQ13 pin set
    // Reserved codes fall back to the first pin set.
    always @(posedge core_clk) begin
        if (!rst_n) begin
            pin_config <= 2'b01;
            mode_reserved <= 1'b0;
        end else if (capture) begin
            pin_config <= (mode_strap == `MODE_PIN_CFG2) ? 2'b10 : 2'b01;
            mode_reserved <= (mode_strap != `MODE_PIN_CFG1) &&
                             (mode_strap != `MODE_PIN_CFG2);
        end
    end

    // RQ2 capture count
    // Counter wraps; software only compares two readings.
    always @(posedge core_clk) begin
        if (!rst_n) begin
            cap_cnt_ff <= 8'h00;
        end else if (capture) begin
            cap_cnt_ff <= cap_cnt_ff + 8'h01;
        end
    end

    // RQ14 lanes disabled together
    // One flop pair per port keeps each lane setting next to its port.
    generate
        for (gi = 0; gi < NUM_PORTS; gi = gi + 1) begin : g_lane
            always @(posedge core_clk) begin
                if (!rst_n) begin
                    usb2_port_off[gi] <= 1'b0;
                    usb3_port_off[gi] <= 1'b0;
                end else begin
                    usb2_port_off[gi] <= strap_off_ff[gi] | sw_off[gi];
                    usb3_port_off[gi] <= strap_off_ff[gi] | sw_off[gi];
                end
            end
        end
    endgenerate

    // Register views
    assign raw_word = ({26'h0, dp_raw_ff} << `RAW_DP_LSB) |
                      ({26'h0, dm_raw_ff} << `RAW_DM_LSB) |
                      ({29'h0, fix_raw_ff} << `RAW_FIX_LSB) |
                      ({29'h0, chg_raw_ff} << `RAW_CHG_LSB) |
                      ({29'h0, mode_raw_ff} << `RAW_MODE_LSB);
    // Decoded view shows the lane state after any software override
    assign cfg_word = ({26'h0, usb2_port_off} << `CFG_OFF_LSB) |
                      ({26'h0, fixed_port_mask} << `CFG_FIX_LSB) |
                      ({26'h0, charge_port_mask} << `CFG_CHG_LSB) |
                      ({30'h0, pin_config} << `CFG_PIN_LSB);
    // Status flags and capture count
    assign stat_word = ({31'h0, state_ff == ST_RUN} << `STAT_RUN_BIT) |
                       ({31'h0, mode_reserved} << `STAT_MODE_RSV_BIT) |
                       ({31'h0, fix_bad_ff} << `STAT_FIX_BAD_BIT) |
                       ({31'h0, chg_bad_ff} << `STAT_CHG_BAD_BIT) |
                       ({24'h0, cap_cnt_ff} << `STAT_CNT_LSB);

    // Unmapped offsets read as zero
    always @* begin
        case (haddr)
            `OFS_RAW: rd_word = raw_word;
            `OFS_CFG: rd_word = cfg_word;
            `OFS_CTRL: rd_word = ctrl_ff;
            `OFS_STAT: rd_word = stat_word;
            default: rd_word = 32'h0000_0000;
        endcase
    end

    // AHB-Lite slave, zero wait states, always OKAY
    // hsize is ignored: every register is a whole word.
    assign addr_phase = hsel && htrans[1] && hready;

    always @(posedge core_clk) begin
        if (!rst_n) begin
            hrdata <= 32'h0000_0000;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
            wr_pend_ff <= 1'b0;
            wr_addr_ff <= 12'h000;
        end else begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
            if (addr_phase) begin
                wr_pend_ff <= hwrite;
                wr_addr_ff <= haddr;
                // Read data is loaded at the address phase edge
                if (!hwrite) begin
                    hrdata <= rd_word;
                end
            end else if (hready) begin
                wr_pend_ff <= 1'b0;
            end
        end
    end

    // Write data comes one cycle after the address, so the address is kept.
    // A read right after a CTRL write still returns the old value.
    always @(posedge core_clk) begin
        if (!rst_n) begin
            ctrl_ff <= `CTRL_RESET;
        end else if (wr_pend_ff && (wr_addr_ff == `OFS_CTRL)) begin
            ctrl_ff <= hwdata;
        end
    end

endmodule // reset_strap_latch

// ### rtl/strap_defines.vh
`ifndef STRAP_DEFINES_VH
`define STRAP_DEFINES_VH

// Register byte offsets
`define OFS_RAW 12'h000
`define OFS_CFG 12'h004
`define OFS_CTRL 12'h008
`define OFS_STAT 12'h00C

// Raw capture register fields
`define RAW_DP_LSB 0
`define RAW_DM_LSB 8
`define RAW_FIX_LSB 16
`define RAW_CHG_LSB 20
`define RAW_MODE_LSB 24

// Decoded configuration register fields
`define CFG_OFF_LSB 0
`define CFG_FIX_LSB 8
`define CFG_CHG_LSB 16
`define CFG_PIN_LSB 24

// Control register fields
`define CTRL_OVR_BIT 0
`define CTRL_MASK_LSB 8
`define CTRL_RESET 32'h0000_0000

// Status register fields
`define STAT_RUN_BIT 0
`define STAT_MODE_RSV_BIT 1
`define STAT_FIX_BAD_BIT 2
`define STAT_CHG_BAD_BIT 3
`define STAT_CNT_LSB 8

// Six-level resistor strap codes
`define LVL_200K_DN 3'h0
`define LVL_200K_UP 3'h1
`define LVL_10K_DN 3'h2
`define LVL_10K_UP 3'h3
`define LVL_10R_DN 3'h4
`define LVL_10R_UP 3'h5

// Mode strap codes, straps 3..1
`define MODE_PIN_CFG1 3'h0
`define MODE_PIN_CFG2 3'h1

`endif

// ### tb/reset_strap_latch_asserts.sv
`timescale 1ns/10ps
module reset_strap_latch_asserts #(
    parameter NUM_PORTS = 6
) (
    // Clock and reset
    input wire core_clk,
    input wire rst_n,
    // Reset pin and straps
    input wire ext_reset_n,
    input wire [NUM_PORTS-1:0] port_dplus_off_strap,
    input wire [NUM_PORTS-1:0] port_dminus_off_strap,
    input wire [2:0] fixed_port_count_strap,
    input wire [2:0] charge_port_count_strap,
    input wire [2:0] mode_strap,
    // Configuration outputs
    input wire dev_reset,
    input wire [NUM_PORTS-1:0] usb2_port_off,
    input wire [NUM_PORTS-1:0] usb3_port_off,
    input wire [NUM_PORTS-1:0] fixed_port_mask,
    input wire [NUM_PORTS-1:0] charge_port_mask,
    input wire [1:0] pin_config,
    input wire mode_reserved
);
    // Codes 6 and 7 count as no ports
    function [5:0] cnt_mask(input [2:0] c);
        cnt_mask = (c == 3'h5) ? 6'h3F : (c > 3'h5) ? 6'h00 : ((6'h01 << c) - 6'h01);
    endfunction
    wire take = dev_reset && ext_reset_n;
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    AST_PIN_RESET: assert property (!ext_reset_n |=> dev_reset)
        else $error("reset pin low but device running");
    AST_LEAVE: assert property (take |=> !dev_reset)
        else $error("capture did not release device");
    AST_PORT_OFF: assert property (take |=> ##1 usb2_port_off ==
        ($past(port_dplus_off_strap, 2) & $past(port_dminus_off_strap, 2)))
        else $error("port off not both straps");
    AST_FIXED: assert property (take |=> fixed_port_mask == cnt_mask($past(fixed_port_count_strap)))
        else $error("fixed port mask wrong");
    AST_CHARGE: assert property (take |=> charge_port_mask == cnt_mask($past(charge_port_count_strap)))
        else $error("charge port mask wrong");
    AST_MODE: assert property (take |=> pin_config == (($past(mode_strap) == 3'h1) ? 2'h2 : 2'h1)
        && mode_reserved == ($past(mode_strap) > 3'h1)) else $error("mode decode wrong");
    AST_LANES: assert property (usb3_port_off == usb2_port_off)
        else $error("usb3 lane differs from usb2");
    AST_HOLD: assert property (!dev_reset && ext_reset_n |=> $stable(fixed_port_mask) &&
        $stable(charge_port_mask) && $stable(pin_config)) else $error("config moved while running");
endmodule // reset_strap_latch_asserts
bind reset_strap_latch reset_strap_latch_asserts #(.NUM_PORTS(NUM_PORTS)) u_asserts (
    .core_clk(core_clk), .rst_n(rst_n), .ext_reset_n(ext_reset_n),
    .port_dplus_off_strap(port_dplus_off_strap), .port_dminus_off_strap(port_dminus_off_strap),
    .fixed_port_count_strap(fixed_port_count_strap),
    .charge_port_count_strap(charge_port_count_strap), .mode_strap(mode_strap),
    .dev_reset(dev_reset), .usb2_port_off(usb2_port_off), .usb3_port_off(usb3_port_off),
    .fixed_port_mask(fixed_port_mask), .charge_port_mask(charge_port_mask),
    .pin_config(pin_config), .mode_reserved(mode_reserved));

// ### tb/reset_strap_latch_tb.sv
`timescale 1ns/10ps
`include "strap_defines.vh"
module reset_strap_latch_tb;
    reg core_clk = 1'b0;
    reg rst_n = 1'b0;
    reg hsel = 1'b0;
    reg [11:0] haddr = 12'h000;
    reg [1:0] htrans = 2'h0;
    reg hwrite = 1'b0;
    reg [31:0] hwdata = 32'h0000_0000;
    wire ext_reset_n, hreadyout, hresp, dev_reset, mode_reserved;
    wire [5:0] dp, dm, u2_off, u3_off, fix_mask, chg_mask;
    wire [2:0] fix, chg, mode;
    wire [1:0] pin_config;
    wire [31:0] hrdata;
    wire [31:0] state = {4'h0, u2_off, u3_off, fix_mask, chg_mask, pin_config, mode_reserved, dev_reset};
    integer error_cnt = 0;
    integer num_checks = 0;
    integer i;
    reg [31:0] rd;
    reg [5:0] pd, pm;
    always #2.5 core_clk = ~core_clk;
    strap_board u_board (.core_clk(core_clk), .ext_reset_n(ext_reset_n), .dplus_off(dp),
        .dminus_off(dm), .fixed_code(fix), .charge_code(chg), .mode_code(mode));
    reset_strap_latch #(.NUM_PORTS(6)) u_dut (.core_clk(core_clk), .rst_n(rst_n),
        .ext_reset_n(ext_reset_n), .port_dplus_off_strap(dp), .port_dminus_off_strap(dm),
        .fixed_port_count_strap(fix), .charge_port_count_strap(chg), .mode_strap(mode),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
        .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
        .hresp(hresp), .dev_reset(dev_reset), .usb2_port_off(u2_off), .usb3_port_off(u3_off),
        .fixed_port_mask(fix_mask), .charge_port_mask(chg_mask), .pin_config(pin_config),
        .mode_reserved(mode_reserved));
    function [5:0] want(input [2:0] c);
        want = (c == 3'h5) ? 6'h3F : (c > 3'h5) ? 6'h00 : ((6'h01 << c) - 6'h01);
    endfunction
    task check(input [31:0] got, input [31:0] exp);
        begin
            num_checks = num_checks + 1;
            if (got !== exp) begin
                error_cnt = error_cnt + 1;
                $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
            end
        end
    endtask
    // Master holds each phase until hready is seen high
    task bus(input wr, input [11:0] a, input [31:0] wd);
        begin
            @(posedge core_clk);
            hsel <= 1'b1;
            haddr <= a;
            hwrite <= wr;
            htrans <= 2'h2;
            @(posedge core_clk);
            while (hreadyout !== 1'b1) @(posedge core_clk);
            hsel <= 1'b0;
            htrans <= 2'h0;
            hwdata <= wd;
            @(posedge core_clk);
            while (hreadyout !== 1'b1) @(posedge core_clk);
            rd = hrdata;
        end
    endtask
    task t_decode;
        for (i = 0; i < 8; i = i + 1) begin
            pd = 6'h2D + i[5:0];
            pm = 6'h1E + i[5:0];
            u_board.pin(1'b0);
            u_board.straps(pd, pm, i[2:0], 3'h7 - i[2:0], i[2:0]);
            #1 check({31'h0, dev_reset}, 32'h1);
            u_board.pin(1'b1);
            repeat (2) @(posedge core_clk);
            #1 check(state, {4'h0, {2{pd & pm}}, want(i[2:0]), want(3'h7 - i[2:0]),
                (i == 1) ? 2'h2 : 2'h1, i > 1, 1'b0});
        end
    endtask
    task t_hold;
        begin
            u_board.straps(6'h3F, 6'h3F, 3'h5, 3'h5, 3'h1);
            repeat (3) @(posedge core_clk);
            #1 check(state, 32'h0924_0006);
            bus(1'b0, `OFS_RAW, 32'h0000_0000);
            check(rd, 32'h0707_2534);
        end
    endtask
    task t_regs;
        begin
            bus(1'b0, `OFS_CFG, 32'h0000_0000);
            check(rd, 32'h0100_0024);
            bus(1'b1, `OFS_RAW, 32'hFFFF_FFFF);
            bus(1'b0, `OFS_RAW, 32'h0000_0000);
            check(rd, 32'h0707_2534);
            bus(1'b0, 12'h010, 32'h0000_0000);
            check({rd[31:1], hresp}, 32'h0000_0000);
            bus(1'b0, `OFS_STAT, 32'h0000_0000);
            check(rd, 32'h0000_0907);
            bus(1'b1, `OFS_CTRL, 32'h0000_1301);
            bus(1'b0, `OFS_CTRL, 32'h0000_0000);
            check(rd, 32'h0000_1301);
            check({20'h0, u2_off, u3_off}, 32'h0000_0DF7);
            bus(1'b1, `OFS_CTRL, 32'h0000_0000);
            bus(1'b0, `OFS_CFG, 32'h0000_0000);
            check(rd, 32'h0100_0024);
        end
    endtask
    task give_verdict;
        begin
            if (error_cnt == 0 && num_checks > 0)
                $display("Test passed");
            else
                $display("Test failed");
            $finish;
        end
    endtask
    initial begin
        #20000;
        error_cnt = error_cnt + 1;
        give_verdict;
    end
    initial begin
        repeat (12) @(posedge core_clk);
        rst_n <= 1'b1;
        t_decode;
        t_hold;
        @(posedge core_clk);
        t_regs;
        give_verdict;
    end
endmodule // reset_strap_latch_tb

// ### tb/strap_board.sv
`timescale 1ns/10ps
module strap_board (
    // Clock
    input wire core_clk,
    // Reset pin and strap levels
    output reg ext_reset_n,
    output reg [5:0] dplus_off,
    output reg [5:0] dminus_off,
    output reg [2:0] fixed_code,
    output reg [2:0] charge_code,
    output reg [2:0] mode_code
);
    initial begin
        ext_reset_n = 1'b1;
        // fixed-port strap fitted, no SPI firmware
        {dplus_off, dminus_off, fixed_code, charge_code, mode_code} = 21'h00_0000;
    end
    task pin(input lvl);
        begin
            @(posedge core_clk);
            ext_reset_n <= lvl;
        end
    endtask
    task straps(input [5:0] dp, input [5:0] dm, input [2:0] fx, input [2:0] cg, input [2:0] md);
        begin
            @(posedge core_clk);
            {dplus_off, dminus_off, fixed_code, charge_code, mode_code} <= {dp, dm, fx, cg, md};
        end
    endtask
endmodule // strap_board
